/* logic/burst_ctrl_pkg.sv */
// Shared constants, state codes and helpers for the burst initiator controller
package burst_ctrl_pkg;
    localparam int          WORD_W        = 30;
    localparam int          LEN_W         = 4;
    localparam int          STAT_W        = 40;
    localparam int          MASTER_ABORT  = 39;
    localparam int          TARGET_ABORT  = 38;
    // Register byte offsets on the APB side
    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_ADDR      = 8'h04;
    localparam logic [7:0]  OFF_LEN       = 8'h08;
    localparam logic [7:0]  OFF_STATUS    = 8'h0C;
    // Control register fields
    localparam int          CTRL_START    = 0;
    localparam int          CTRL_WRITE    = 1;
    // Status register fields
    localparam int          ST_STATE_LSB  = 0;
    localparam int          ST_ABORT      = 4;
    localparam int          ST_ZERO       = 5;
    localparam int          ST_PREP       = 6;
    localparam int          ST_REM_LSB    = 8;
    localparam int          ST_SPEC_LSB   = 12;
    // Reset values and word pointer step
    localparam logic [31:0] ADDR_RST      = 32'h0000_0000;
    localparam logic [3:0]  LEN_RST       = 4'h0;
    localparam logic [3:0]  REM_RST       = 4'h0;
    localparam logic [29:0] PTR_STEP      = 30'h0000_0001;
    // Bus command and byte lanes
    localparam logic [2:0]  CMD_MEM_PFX   = 3'h3;
    localparam logic [3:0]  BYTE_EN_ALL   = 4'h0;
    // Remaining-count thresholds for the finish request
    localparam logic [3:0]  REM_ONE       = 4'h1;
    localparam logic [3:0]  REM_TWO       = 4'h2;
    localparam logic [3:0]  REM_THREE     = 4'h3;
    // Speculative excess counter bounds
    localparam logic [1:0]  SPEC_MIN      = 2'h0;
    localparam logic [1:0]  SPEC_MAX      = 2'h3;

    typedef enum logic [2:0] {
        ST_WAIT   = 3'b000,
        ST_REQ    = 3'b001,
        ST_WRITE  = 3'b010,
        ST_READ   = 3'b011,
        ST_HALT   = 3'b100,
        ST_REWIND = 3'b101
    } seq_state_e;

    // Saturating two-bit step: one increment, two decrements, one cycle
    function automatic logic [1:0] spec_step(input logic [1:0] cnt,
                                             input logic       up,
                                             input logic       dn_a,
                                             input logic       dn_b);
        logic [2:0] up_v;
        logic [2:0] dn_v;
        logic [2:0] diff;
        up_v = {1'b0, cnt} + {2'b00, up};
        dn_v = {2'b00, dn_a} + {2'b00, dn_b};
        diff = up_v - dn_v;
        if (up_v <= dn_v)
            return SPEC_MIN;
        else if (diff > {1'b0, SPEC_MAX})
            return SPEC_MAX;
        else
            return diff[1:0];
    endfunction : spec_step
endpackage : burst_ctrl_pkg

/* logic/xfer_track_if.sv */
// Carrier between the sequencer and the word/speculation tracker
`timescale 1ns/1ns
`default_nettype none
interface xfer_track_if;
    import burst_ctrl_pkg::*;
    logic             start;       // Load remaining-word counter
    logic [LEN_W-1:0] burst_len;   // Words to move
    logic             word_done;   // Actual transfer
    logic             anticipated; // Speculative fetch counted
    logic             rewind;      // FIFO backed up one entry
    logic [1:0]       spec_cnt;    // Speculative excess
    logic [LEN_W-1:0] remaining;   // Words still to move
    logic             count_zero;  // Nothing left
    modport tracker (input start, burst_len, word_done, anticipated, rewind,
                     output spec_cnt, remaining, count_zero);
    modport seq (output start, burst_len, word_done, anticipated, rewind,
                 input spec_cnt, remaining, count_zero);
endinterface : xfer_track_if
`default_nettype wire

/* logic/xfer_tracker.sv */
// Remaining-word counter and speculative excess counter
`timescale 1ns/1ns
`default_nettype none
module xfer_tracker
    import burst_ctrl_pkg::*;
(
    input  wire logic     ref_clk,  // System clock
    input  wire logic     rst,      // Async reset, active high
    xfer_track_if.tracker trk       // Counter requests and results
);
    logic [LEN_W-1:0] remaining_words_q;
    logic [1:0]       spec_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            remaining_words_q <= REM_RST;
        else if (trk.start)
            remaining_words_q <= trk.burst_len; // R21
        else if (trk.word_done)
            remaining_words_q <= remaining_words_q - REM_ONE; // R21
    end

    // Net change of all three events lands in one cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            spec_q <= SPEC_MIN;
        else
            spec_q <= spec_step(spec_q, trk.anticipated, trk.word_done,
                                trk.rewind); // R16
    end

    assign trk.remaining  = remaining_words_q;
    assign trk.spec_cnt   = spec_q;
    assign trk.count_zero = (remaining_words_q == REM_RST); // R21

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    spec_sat_a: assert property (spec_q == SPEC_MAX && trk.anticipated
        && !trk.word_done && !trk.rewind |=> spec_q == SPEC_MAX) // R16
        else $error("speculative count left its upper bound");
    spec_net_a: assert property (spec_q == 2'h2 && !trk.anticipated
        && trk.word_done && trk.rewind |=> spec_q == SPEC_MIN) // R16
        else $error("two decrements not applied in one cycle");
    rem_load_a: assert property (trk.start
        |=> remaining_words_q == $past(trk.burst_len)) // R21
        else $error("remaining count not loaded on start");
endmodule : xfer_tracker
`default_nettype wire

/* logic/burst_initiator_fifo_ctrl.sv */
// Burst initiator controller driving an interface core from a local FIFO
// Overview of operation
// [R1] Reset or bad code gives waiting; waiting leaves for request only on start.
// [R2] Request lasts one cycle, then write state if write_select, else read.
// [R3] Transfer states wait for data_phase_end, then halt on abort or rewind check.
// [R4] Abort halt state is left only by reset.
// [R5] Rewind check holds while rewinding, then waits if count zero, else requests.
// [R6] user_side_prepared comes from a flop: 0 in reset, 1 afterwards.
// [R7] bus_access_pulse is one cycle, in the request state.
// [R8] Core requests the bus only once its bus master enable is set.
// [R9] hold_bus_access is held low.
// [R10] Word pointer loads start address, counts words, drives bus in address phase.
// [R11] Address phase shows memory read/write command; otherwise all bytes enabled.
// [R12] write_not_read_out follows write_select from a flop, steady per transaction.
// [R13] Finish request on count 1, 2 or 3 conditions, held until data_phase_end.
// [R14] Anticipated transfer counts source_advance only while FIFO not empty.
// [R15] Core marks done words and speculative fetches with separate strobes.
// [R16] Two-bit speculative count saturates; one up, two downs, net per cycle.
// [R17] fifo_rewind only in rewind check with non-zero speculative count.
// [R18] Push on read words, pop on write advance, drive out in write data phase.
// [R19] data_phase_end is the falling edge of the core's data phase flag.
// [R20] abort_seen clears in address phase, captures abort bits in data phase.
// [R21] Remaining counter loads length on start, decrements per word; zero flagged.
// [R22] No write start on empty FIFO, no read start on full; direction steady.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module burst_initiator_fifo_ctrl
    import burst_ctrl_pkg::*;
(
    input  wire logic                                ref_clk,   // 20 MHz
    input  wire logic                                rst,       // Async, high
    input  wire logic                                psel,      // APB select
    input  wire logic                                penable,   // APB enable
    input  wire logic                                pwrite,    // APB write
    input  wire logic [7:0]                          paddr,     // APB address
    input  wire logic [31:0]                         pwdata,    // APB wdata
    output logic      [31:0]                         prdata,    // APB rdata
    output logic                                     pready,    // APB ready
    output logic                                     pslverr,   // APB error
    input  wire logic                                addr_phase_strobe_low,
                                                                // Addr phase
    input  wire logic                                data_phase_flag, // Data ph
    input  wire logic                                core_word_transferred,
                                                                // Word moved
    input  wire logic                                source_advance, // Fetch
    input  wire logic [burst_ctrl_pkg::STAT_W-1:0]   core_status_vector,
                                                                // Ext status
    output logic                                     bus_access_pulse, // Req
    output logic                                     hold_bus_access, // Low
    output logic                                     user_side_prepared,
                                                                // Ready
    output logic                                     finish_request, // Done
    output logic                                     write_not_read_out,
                                                                // Direction
    output logic      [3:0]                          cmd_byte_lanes, // C/BE
    output logic      [31:0]                         shared_addr_data_bus_out,
                                                                // Address
    output logic                                     shared_addr_data_bus_oe,
                                                                // Drive en
    input  wire logic                                fifo_empty_flag, // Empty
    input  wire logic                                fifo_full_flag, // Full
    output logic                                     buffer_push, // FIFO wr
    output logic                                     buffer_pop,  // FIFO rd
    output logic                                     buffer_drive_out, // OE
    output logic                                     fifo_rewind  // Back up
);
    import burst_ctrl_pkg::*;

    seq_state_e       state_q;
    seq_state_e       state_d;
    logic [31:0]      initial_bus_addr_q;
    logic [LEN_W-1:0] burst_len_q;
    logic             write_select_q;
    logic             start_q;
    logic [WORD_W-1:0] addr_ptr_q;
    logic             delayed_data_phase_flag;
    logic             abort_seen_q;
    logic             finish_hold_q;
    logic             req_q;
    logic             wrdn_q;
    logic             prepared_q;
    logic             hold_q;
    logic             rewind_q;
    logic             pready_q;
    logic             pslverr_q;
    logic [31:0]      prdata_q;

    xfer_track_if trk ();

    xfer_tracker u_tracker (
        .ref_clk (ref_clk),
        .rst     (rst),
        .trk     (trk)
    );

    // APB decode
    wire apb_setup   = psel & ~penable;
    wire apb_wr      = psel & penable & pwrite & pready_q;
    wire hit_ctrl    = (paddr == OFF_CTRL);
    wire hit_addr    = (paddr == OFF_ADDR);
    wire hit_len     = (paddr == OFF_LEN);
    wire hit_status  = (paddr == OFF_STATUS);
    wire hit_any     = hit_ctrl | hit_addr | hit_len | hit_status;
    wire idle        = (state_q == ST_WAIT);
    wire wr_ctrl     = apb_wr & hit_ctrl & idle;
    wire new_dir     = pwdata[CTRL_WRITE];
    // Starting a write on an empty FIFO or a read on a full one would lose data, so refuse it
    wire start_ok    = new_dir ? ~fifo_empty_flag : ~fifo_full_flag; // R22
    wire start_req   = wr_ctrl & pwdata[CTRL_START] & start_ok; // R22

    wire [31:0] status_word = {
        16'h0000,
        2'h0, trk.spec_cnt,
        trk.remaining,
        1'b0, prepared_q, trk.count_zero, abort_seen_q,
        1'b0, state_q
    };
    logic [31:0] rd_mux;
    always_comb begin
        if (hit_ctrl)
            rd_mux = {30'h0, write_select_q, 1'b0};
        else if (hit_addr)
            rd_mux = initial_bus_addr_q;
        else if (hit_len)
            rd_mux = {28'h0, burst_len_q};
        else if (hit_status)
            rd_mux = status_word;
        else
            rd_mux = 32'h0000_0000;
    end

    // Registers answer after one setup cycle; no wait states
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= apb_setup;
            pslverr_q <= apb_setup & ~hit_any;
            prdata_q  <= apb_setup ? rd_mux : 32'h0000_0000;
        end
    end

    // Settings change only while waiting, which keeps direction stable
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            initial_bus_addr_q <= ADDR_RST;
            burst_len_q        <= LEN_RST;
            write_select_q     <= 1'b0;
            start_q            <= 1'b0;
        end else begin
            if (apb_wr & hit_addr & idle)
                initial_bus_addr_q <= pwdata;
            if (apb_wr & hit_len & idle)
                burst_len_q <= pwdata[LEN_W-1:0];
            if (wr_ctrl)
                write_select_q <= new_dir; // R22
            start_q <= start_req;
        end
    end

    // Core-side decode
    wire data_phase_end = ~data_phase_flag & delayed_data_phase_flag; // R19
    wire in_xfer        = (state_q == ST_WRITE) | (state_q == ST_READ);
    wire anticipated    = source_advance & ~fifo_empty_flag; // R14
    wire [3:0] command  = {CMD_MEM_PFX, write_select_q};
    wire rem_one        = (trk.remaining == REM_ONE);
    wire rem_two        = (trk.remaining == REM_TWO);
    wire rem_three      = (trk.remaining == REM_THREE);
    wire finish_now     = (rem_one & req_q)
                        | (rem_two & delayed_data_phase_flag)
                        | (rem_three & core_word_transferred); // R13

    assign trk.start       = start_q;
    assign trk.burst_len   = burst_len_q;
    assign trk.word_done   = core_word_transferred; // R15
    assign trk.anticipated = anticipated; // R15
    assign trk.rewind      = rewind_q;

    always_comb begin
        case (state_q)
            ST_WAIT:   state_d = start_q ? ST_REQ : ST_WAIT; // R1
            ST_REQ:    state_d = write_select_q ? ST_WRITE : ST_READ; // R2
            ST_WRITE,
            ST_READ: begin
                if (data_phase_end)
                    state_d = abort_seen_q ? ST_HALT : ST_REWIND; // R3
                else
                    state_d = state_q;
            end
            ST_HALT:   state_d = ST_HALT; // R4
            ST_REWIND: begin
                if (rewind_q)
                    state_d = ST_REWIND; // R5
                else if (trk.count_zero)
                    state_d = ST_WAIT; // R5
                else
                    state_d = ST_REQ; // R5
            end
            default:   state_d = ST_WAIT; // R1
        endcase
    end

    // Spec count one cycle ahead, so the flop matches the state it gates
    wire [1:0] spec_next = spec_step(trk.spec_cnt, anticipated,
                                     core_word_transferred, rewind_q);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q  <= ST_WAIT; // R1
            req_q    <= 1'b0;
            rewind_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            req_q    <= (state_d == ST_REQ); // R7
            rewind_q <= (state_d == ST_REWIND) & (|spec_next); // R17
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            delayed_data_phase_flag <= 1'b0; // R19
            abort_seen_q            <= 1'b0;
            finish_hold_q           <= 1'b0;
            addr_ptr_q              <= '0;
        end else begin
            delayed_data_phase_flag <= data_phase_flag;
            // Extended status is valid only during the data phase, so keep it here
            if (!addr_phase_strobe_low)
                abort_seen_q <= 1'b0; // R20
            else if (data_phase_flag)
                abort_seen_q <= core_status_vector[MASTER_ABORT]
                              | core_status_vector[TARGET_ABORT]; // R20
            if (data_phase_end)
                finish_hold_q <= 1'b0; // R13
            else if (finish_now)
                finish_hold_q <= 1'b1; // R13
            if (start_q)
                addr_ptr_q <= initial_bus_addr_q[31:2]; // R10
            else if (core_word_transferred)
                addr_ptr_q <= addr_ptr_q + PTR_STEP; // R10
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wrdn_q     <= 1'b0;
            prepared_q <= 1'b0; // R6
            hold_q     <= 1'b0;
        end else begin
            wrdn_q     <= write_select_q; // R12
            prepared_q <= 1'b1; // R6
            hold_q     <= 1'b0; // R9
        end
    end

    // Core timing leaves no cycle to register these against its strobes
    assign finish_request     = finish_now | finish_hold_q; // R13
    assign cmd_byte_lanes     = addr_phase_strobe_low ? BYTE_EN_ALL
                                                      : command; // R11
    assign shared_addr_data_bus_oe  = ~addr_phase_strobe_low; // R10
    assign shared_addr_data_bus_out = {addr_ptr_q, 2'b00}; // R10
    assign buffer_push      = (state_q == ST_READ) & core_word_transferred; // R18
    assign buffer_pop       = (state_q == ST_WRITE) & source_advance; // R18
    assign buffer_drive_out = (state_q == ST_WRITE) & data_phase_flag; // R18
    assign bus_access_pulse   = req_q;
    assign hold_bus_access    = hold_q;
    assign user_side_prepared = prepared_q;
    assign write_not_read_out = wrdn_q;
    assign fifo_rewind        = rewind_q;
    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence xfer_ending;
        in_xfer && data_phase_end;
    endsequence
    sequence finish_raised;
        finish_request && !data_phase_end;
    endsequence

    wait_hold_a: assert property (idle && !start_q |=> idle) // R1
        else $error("left waiting without start");
    req_branch_a: assert property (state_q == ST_REQ |=> state_q ==
        (write_select_q ? ST_WRITE : ST_READ)) // R2
        else $error("request state did not branch on direction");
    abort_halt_a: assert property (xfer_ending and abort_seen_q
        |=> state_q == ST_HALT) // R3
        else $error("abort did not reach halt");
    halt_stuck_a: assert property (state_q == ST_HALT
        |=> state_q == ST_HALT [*3]) // R4
        else $error("halt state was left");
    rewind_stay_a: assert property (state_q == ST_REWIND && fifo_rewind
        |=> state_q == ST_REWIND) // R5
        else $error("rewind check left while rewinding");
    pulse_single_a: assert property (bus_access_pulse
        |-> state_q == ST_REQ ##1 !bus_access_pulse) // R7
        else $error("bus access pulse not single cycle");
    addr_phase_a: assert property (!addr_phase_strobe_low
        |-> shared_addr_data_bus_oe && cmd_byte_lanes == command) // R11
        else $error("address phase lacks command or address");
    ptr_step_a: assert property (core_word_transferred && !start_q
        |=> addr_ptr_q == $past(addr_ptr_q) + PTR_STEP) // R10
        else $error("word pointer did not advance");
    finish_keep_a: assert property (finish_raised
        |=> finish_request) // R13
        else $error("finish request dropped before data phase end");
    rewind_gate_a: assert property (fifo_rewind |-> state_q == ST_REWIND
        && trk.spec_cnt != SPEC_MIN) // R17
        else $error("rewind outside check state or with zero count");
    prep_flag_a: assert property ($past(prepared_q)
        |-> user_side_prepared) // R6
        else $error("prepared flag fell after reset");
endmodule : burst_initiator_fifo_ctrl
`default_nettype wire

/* test/core_model.sv */
// Behavioural interface core: address phase, prefetch and data words
`timescale 1ns/1ns
`default_nettype none
module core_model
    import burst_ctrl_pkg::*;
(
    input  wire logic         ref_clk,  // Clock
    input  wire logic         rst,      // Async reset
    input  wire logic         req,      // Bus access pulse
    input  wire logic         en,       // Bus master enable
    input  wire logic         abort,    // Report abort in data phase
    input  wire logic [3:0]   len,      // Words of the whole burst
    input  wire logic [3:0]   lim,      // Words before disconnect
    output logic              strobe_n, // Address phase, low
    output logic              flag,     // Data phase
    output logic              word,     // Word moved
    output logic              adv,      // Source fetch
    output logic [STAT_W-1:0] stat      // Extended status
);
    logic [3:0] left, cur, n, k;
    logic [1:0] ph;
    assign cur = (left == 4'h0) ? len : left;
    assign n = (cur < lim) ? cur : lim;
    assign strobe_n = (ph != 2'h1);
    assign flag = (ph == 2'h3);
    assign word = flag;
    // Fetch runs one word ahead, so every transaction leaves one excess
    assign adv = ph[1];
    assign stat = {abort & flag, {(STAT_W-1){1'b0}}};
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ph <= 2'h0;
            left <= 4'h0;
            k <= 4'h0;
        end else if (ph == 2'h0) begin
            if (req && en) begin
                ph <= 2'h1;
                k <= n;
                left <= cur - n;
            end
        end else if (ph != 2'h3) begin
            ph <= ph + 2'h1;
        end else begin
            k <= k - 4'h1;
            if (k == 4'h1) ph <= 2'h0;
        end
    end
endmodule : core_model
`default_nettype wire

/* test/burst_initiator_fifo_ctrl_test.sv */
// Self-checking bench for the burst initiator controller
`timescale 1ns/1ns
`default_nettype none
module burst_initiator_fifo_ctrl_test;
    import burst_ctrl_pkg::*;
    logic ref_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, en = 1'h1, abort = 1'h0, dir = 1'h0, rerr;
    logic fifo_empty_flag = 1'h0, fifo_full_flag = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, shared_addr_data_bus_out, rdat, ptr;
    logic pready, pslverr, addr_phase_strobe_low, data_phase_flag;
    logic core_word_transferred, source_advance, bus_access_pulse;
    logic hold_bus_access, user_side_prepared, finish_request;
    logic write_not_read_out, shared_addr_data_bus_oe, buffer_push;
    logic buffer_pop, buffer_drive_out, fifo_rewind;
    logic [3:0] cmd_byte_lanes, blen = 4'h1, blim = 4'h1, dl, ln, lm;
    logic [STAT_W-1:0] core_status_vector;
    // Direction, length, words per transaction, start address
    logic [43:0] rows [5] = '{44'h1_4_4_00001000, 44'h0_3_2_20000FF8,
        44'h1_1_1_FFFFFFFC, 44'h0_F_F_00000040, 44'h1_5_2_00000100};
    int fail_count = 0, compares = 0, cyc = 0, t;
    logic [31:0] n_req, n_push, n_pop, n_drv, n_rew;
    burst_initiator_fifo_ctrl uut (.ref_clk, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .addr_phase_strobe_low,
        .data_phase_flag, .core_word_transferred, .source_advance,
        .core_status_vector, .bus_access_pulse, .hold_bus_access,
        .user_side_prepared, .finish_request, .write_not_read_out,
        .cmd_byte_lanes, .shared_addr_data_bus_out, .shared_addr_data_bus_oe,
        .fifo_empty_flag, .fifo_full_flag, .buffer_push, .buffer_pop,
        .buffer_drive_out, .fifo_rewind);
    core_model core (.ref_clk, .rst, .req(bus_access_pulse), .en, .abort,
        .len(blen), .lim(blim), .strobe_n(addr_phase_strobe_low),
        .flag(data_phase_flag), .word(core_word_transferred),
        .adv(source_advance), .stat(core_status_vector));
    initial forever #25 ref_clk = ~ref_clk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wrap_up;
        if (fail_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do @(posedge ref_clk); while (pready !== 1'h1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic poll(input logic [2:0] st);
        do apb(1'h0, OFF_STATUS, 32'h0);
        while (rdat[2:0] !== st || n_req == 0);
    endtask : poll
    task automatic do_reset;
        rst <= 1'h1;
        // Reset clears the start address, so the next burst starts there
        ptr = ADDR_RST;
        repeat (16) @(posedge ref_clk);
        chk(user_side_prepared, 32'h0);
        rst <= 1'h0;
        repeat (2) @(posedge ref_clk);
        chk(user_side_prepared, 32'h1);
    endtask : do_reset
    // Port-level watch; the cycle ceiling cuts a hung handshake short
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 20000) begin
            fail_count++;
            wrap_up;
        end
        if (!rst) begin
            chk(shared_addr_data_bus_oe, !addr_phase_strobe_low);
            chk(hold_bus_access, 32'h0);
            if (bus_access_pulse && ln == 4'h1)
                chk(finish_request, 32'h1);
            if (!addr_phase_strobe_low) begin
                chk(cmd_byte_lanes, {3'h3, dir});
                chk(shared_addr_data_bus_out, ptr);
            end else
                chk(cmd_byte_lanes, 32'h0);
            if (data_phase_flag) chk(write_not_read_out, dir);
            n_req += bus_access_pulse;
            n_push += buffer_push;
            n_pop += buffer_pop;
            n_drv += buffer_drive_out;
            n_rew += fifo_rewind;
            if (core_word_transferred) ptr += 32'h4;
        end
    end
    initial begin
        do_reset;
        foreach (rows[i]) begin
            {dl, ln, lm, ptr} = rows[i];
            dir <= dl[0];
            blen <= ln;
            blim <= lm;
            t = (ln + lm - 1) / lm;
            {n_req, n_push, n_pop, n_drv, n_rew} = '0;
            apb(1'h1, OFF_ADDR, ptr);
            apb(1'h1, OFF_LEN, {28'h0, ln});
            apb(1'h1, OFF_CTRL, {30'h0, dl[0], 1'h1});
            poll(3'h0);
            chk(n_req, t);
            chk(n_push, dl[0] ? 0 : ln);
            chk(n_pop, dl[0] ? ln + t : 0);
            chk(n_drv, dl[0] ? ln : 0);
            chk(n_rew, t);
            chk(finish_request, 32'h0);
            chk(shared_addr_data_bus_out, rows[i][31:0] + 4 * ln);
            chk(rdat & 32'h3F7F, 32'h60);
        end
        fifo_empty_flag <= 1'h1;
        fifo_full_flag <= 1'h1;
        apb(1'h1, OFF_CTRL, 32'h3);
        apb(1'h1, OFF_CTRL, 32'h1);
        apb(1'h0, OFF_STATUS, 32'h0);
        chk(rdat[2:0], 32'h0);
        fifo_empty_flag <= 1'h0;
        fifo_full_flag <= 1'h0;
        apb(1'h0, 8'h10, 32'h0);
        chk(rerr, 32'h1);
        en <= 1'h0;
        apb(1'h1, OFF_CTRL, 32'h3);
        poll(3'h2);
        repeat (30) @(posedge ref_clk);
        apb(1'h0, OFF_STATUS, 32'h0);
        chk(rdat[2:0], 32'h2);
        en <= 1'h1;
        do_reset;
        abort <= 1'h1;
        apb(1'h1, OFF_CTRL, 32'h3);
        poll(3'h4);
        chk(rdat[4], 32'h1);
        apb(1'h1, OFF_CTRL, 32'h3);
        repeat (10) @(posedge ref_clk);
        apb(1'h0, OFF_STATUS, 32'h0);
        chk(rdat[2:0], 32'h4);
        abort <= 1'h0;
        do_reset;
        apb(1'h0, OFF_STATUS, 32'h0);
        chk(rdat[2:0], 32'h0);
        wrap_up;
    end
endmodule : burst_initiator_fifo_ctrl_test
`default_nettype wire
